/* design/trigger_holdoff_qualifier.sv */
/*
  Trigger qualifier: source select, level compare with dB offset, slope,
  dead-time or gap holdoff, auto sweep and per-source skew trim.
  Assumes rf_level_i on the same clock, trigger pins asynchronous.
*/
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - Positive slope: trigger when source rises through the threshold.
// - Negative slope: trigger when source falls through the threshold.
// - Holdoff set in 0.01 us units, with 1 us coarse steps.
// - Two holdoff modes, dead-time and quiet-interval, chosen by a mode bit.
// - Dead-time: timer starts on accepted edge, further edges ignored.
// - After dead-time expires, trigger re-arms; next edge starts a sweep.
// - Quiet-interval: arm only after source inactive for the holdoff time.
// - Once armed after the quiet gap, next selected edge triggers.
// - Effective level and its allowed range shift up by the dB offset.
// - Skew trim is added to the trigger delay for the acquisition.
// - Separate skew trim per source class; active source's one applied.
// - Source: own RF input, external input, or another channel.
// - Auto mode sweeps alone after an edge-free period, then resyncs.
module trigger_holdoff_qualifier #(
  parameter int AUTO_CYCLES = trig_qual_pkg::AUTO_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clock_en_i,
  input wire logic signed [15:0] rf_level_i,
  input wire logic multi_io_input_i,
  input wire logic cross_trig_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic trigger_o,
  output logic sweep_start_o,
  output logic armed_o,
  output logic [31:0] acq_delay_o
);

  localparam int CW = trig_qual_pkg::CNT_W;
  localparam int LW = trig_qual_pkg::LVL_W;
  localparam int HW = trig_qual_pkg::HO_W;

  // ****************************************
  // Registers
  // ****************************************
  trig_qual_pkg::trig_ctrl_t ctrl, next_ctrl;
  logic signed [LW-1:0] level, next_level;
  logic signed [LW-1:0] offset, next_offset;
  logic [HW-1:0] holdoff, next_holdoff;
  logic signed [31:0] delay, next_delay;
  logic signed [LW-1:0] skew [3], next_skew [3];
  logic [31:0] next_rd_data;

  logic signed [LW:0] eff_level;
  logic signed [LW:0] eff_level_max;
  logic signed [LW-1:0] wr_level;
  logic signed [LW-1:0] skew_sel;
  logic [HW:0] ho_up;

  always_comb begin
    eff_level = (LW+1)'(level) + (LW+1)'(offset);
    eff_level_max = (LW+1)'(trig_qual_pkg::LEVEL_MAX)
      + (LW+1)'(offset);
    wr_level = signed'(wr_data_i[LW-1:0]);
    ho_up = (HW+1)'(holdoff) + (HW+1)'(trig_qual_pkg::HO_COARSE_UNITS);
    next_ctrl = ctrl;
    next_level = level;
    next_offset = offset;
    next_holdoff = holdoff;
    next_delay = delay;
    next_skew = skew;
    if (wr_i) begin
      case (addr_i)
        trig_qual_pkg::REG_CTRL: begin
          next_ctrl.neg_slope = wr_data_i[trig_qual_pkg::CTRL_NEG_BIT];
          next_ctrl.gap_mode = wr_data_i[trig_qual_pkg::CTRL_GAP_BIT];
          next_ctrl.source = trig_qual_pkg::trig_src_t'(
            wr_data_i[trig_qual_pkg::CTRL_SRC_LSB +: 2]);
          next_ctrl.auto_en = wr_data_i[trig_qual_pkg::CTRL_AUTO_BIT];
        end
        trig_qual_pkg::REG_LEVEL: begin
          // Set point limited to the fixed LEVEL_MAX; only the effective limit moves with the offset
          if (wr_level > trig_qual_pkg::LEVEL_MAX) begin
            next_level = trig_qual_pkg::LEVEL_MAX;
          end else begin
            next_level = wr_level;
          end
        end
        trig_qual_pkg::REG_OFFSET: begin
          next_offset = signed'(wr_data_i[LW-1:0]);
        end
        trig_qual_pkg::REG_HOLDOFF: begin
          next_holdoff = wr_data_i[HW-1:0];
        end
        trig_qual_pkg::REG_HO_STEP: begin
          if (wr_data_i[trig_qual_pkg::STEP_UP_BIT]) begin
            next_holdoff = ho_up[HW] ? '1 : ho_up[HW-1:0];
          end else if (wr_data_i[trig_qual_pkg::STEP_DN_BIT]) begin
            if (holdoff > HW'(trig_qual_pkg::HO_COARSE_UNITS)) begin
              next_holdoff = holdoff
                - HW'(trig_qual_pkg::HO_COARSE_UNITS);
            end else begin
              next_holdoff = '0;
            end
          end
        end
        trig_qual_pkg::REG_DELAY: begin
          next_delay = signed'(wr_data_i);
        end
        trig_qual_pkg::REG_SKEW_INT: begin
          next_skew[0] = signed'(wr_data_i[LW-1:0]);
        end
        trig_qual_pkg::REG_SKEW_EXT: begin
          next_skew[1] = signed'(wr_data_i[LW-1:0]);
        end
        trig_qual_pkg::REG_SKEW_SLV: begin
          next_skew[2] = signed'(wr_data_i[LW-1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] ext_sync, next_ext_sync;
  logic [1:0] cross_sync, next_cross_sync;

  always_comb begin
    next_ext_sync = {ext_sync[0], multi_io_input_i};
    next_cross_sync = {cross_sync[0], cross_trig_i};
  end

  // ****************************************
  // Source, slope and edge detection
  // ****************************************
  logic src_high;
  logic src_active;
  logic high_prev, next_high_prev;
  logic rise_seen;
  logic fall_seen;
  logic edge_seen;
  logic [CW-1:0] ho_ns;
  logic [CW-1:0] hold_cycles;

  always_comb begin
    case (ctrl.source)
      trig_qual_pkg::SRC_EXT: src_high = ext_sync[1];
      trig_qual_pkg::SRC_CROSS: src_high = cross_sync[1];
      default: src_high = ((LW+1)'(rf_level_i) >= eff_level);
    endcase
    // Active means above level for rising, below for falling
    src_active = ctrl.neg_slope ? !src_high : src_high;
    // Edge from the raw crossing, so a slope change is no edge
    next_high_prev = src_high;
    rise_seen = src_high && !high_prev;
    fall_seen = !src_high && high_prev;
    edge_seen = ctrl.neg_slope ? fall_seen : rise_seen;
    ho_ns = CW'(holdoff) * CW'(trig_qual_pkg::HO_UNIT_NS);
    hold_cycles = CW'((ho_ns + CW'(trig_qual_pkg::CLK_PERIOD_NS - 1))
      / CW'(trig_qual_pkg::CLK_PERIOD_NS));
  end

  // ****************************************
  // Skew trim of the active source
  // ****************************************
  always_comb begin
    case (ctrl.source)
      trig_qual_pkg::SRC_EXT: skew_sel = skew[1];
      trig_qual_pkg::SRC_CROSS: skew_sel = skew[2];
      default: skew_sel = skew[0];
    endcase
  end

  // ****************************************
  // Holdoff and auto sweep
  // ****************************************
  logic ho_busy;
  logic ho_load;
  logic fire;
  logic auto_busy;
  logic auto_fire;
  logic auto_load;
  logic [15:0] trig_count, next_trig_count;
  logic next_trigger, next_sweep, next_armed;
  logic [31:0] next_acq_delay;

  always_comb begin
    // Armed when the holdoff timer is idle; zero holdoff never loads it
    fire = edge_seen && !ho_busy;
    if (ctrl.gap_mode) begin
      ho_load = src_active && (hold_cycles != '0);
    end else begin
      ho_load = fire && (hold_cycles != '0);
    end
    auto_fire = ctrl.auto_en && !auto_busy && !fire;
    auto_load = edge_seen || fire || auto_fire;
    next_trigger = fire;
    next_sweep = fire || auto_fire;
    next_armed = !ho_busy;
    next_acq_delay = acq_delay_o;
    if (next_sweep) begin
      next_acq_delay = 32'(delay + 32'(skew_sel));
    end
    next_trig_count = fire ? trig_count + 16'h0001 : trig_count;
  end

  qual_timer #(
    .W(CW)
  ) u_holdoff (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(clock_en_i),
    .load_i(ho_load),
    .load_value_i(hold_cycles),
    .busy_o(ho_busy)
  );

  qual_timer #(
    .W(32)
  ) u_auto (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(clock_en_i),
    .load_i(auto_load),
    .load_value_i(32'(AUTO_CYCLES)),
    .busy_o(auto_busy)
  );

  // ****************************************
  // Read back
  // ****************************************
  always_comb begin
    next_rd_data = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        trig_qual_pkg::REG_CTRL: next_rd_data = 32'(ctrl);
        trig_qual_pkg::REG_LEVEL: next_rd_data = 32'(level);
        trig_qual_pkg::REG_OFFSET: next_rd_data = 32'(offset);
        trig_qual_pkg::REG_HOLDOFF: next_rd_data = 32'(holdoff);
        trig_qual_pkg::REG_DELAY: next_rd_data = delay;
        trig_qual_pkg::REG_SKEW_INT: next_rd_data = 32'(skew[0]);
        trig_qual_pkg::REG_SKEW_EXT: next_rd_data = 32'(skew[1]);
        trig_qual_pkg::REG_SKEW_SLV: next_rd_data = 32'(skew[2]);
        trig_qual_pkg::REG_STATUS: begin
          next_rd_data[trig_qual_pkg::STAT_ARMED_BIT] = armed_o;
          next_rd_data[trig_qual_pkg::STAT_ACTIVE_BIT] =
            high_prev ^ ctrl.neg_slope;
          next_rd_data[trig_qual_pkg::STAT_CNT_LSB +: 16] = trig_count;
        end
        trig_qual_pkg::REG_EFF_LEVEL: next_rd_data = 32'(eff_level);
        trig_qual_pkg::REG_LEVEL_MAX: next_rd_data = 32'(eff_level_max);
        default: next_rd_data = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= trig_qual_pkg::CTRL_RST;
      level <= trig_qual_pkg::LEVEL_RST;
      offset <= 16'sh0000;
      holdoff <= '0;
      delay <= 32'sh00000000;
      skew <= '{default: 16'sh0000};
      ext_sync <= 2'h0;
      cross_sync <= 2'h0;
      high_prev <= 1'b0;
      trig_count <= 16'h0000;
      rd_data_o <= 32'h00000000;
      trigger_o <= 1'b0;
      sweep_start_o <= 1'b0;
      armed_o <= 1'b0;
      acq_delay_o <= 32'h00000000;
    end else if (clock_en_i) begin
      ctrl <= next_ctrl;
      level <= next_level;
      offset <= next_offset;
      holdoff <= next_holdoff;
      delay <= next_delay;
      skew <= next_skew;
      ext_sync <= next_ext_sync;
      cross_sync <= next_cross_sync;
      high_prev <= next_high_prev;
      trig_count <= next_trig_count;
      rd_data_o <= next_rd_data;
      trigger_o <= next_trigger;
      sweep_start_o <= next_sweep;
      armed_o <= next_armed;
      acq_delay_o <= next_acq_delay;
    end
  end

endmodule // trigger_holdoff_qualifier

/* design/trig_qual_pkg.sv */
/*
  Constants, register map and carrier types for the trigger qualifier.
  Assumes a 10 MHz acquisition clock and a plain register port.
*/
package trig_qual_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int HO_UNIT_NS = 10;
  localparam int HO_COARSE_US = 1;
  localparam int HO_COARSE_UNITS = HO_COARSE_US * 1000 / HO_UNIT_NS;
  localparam int AUTO_TIMEOUT_MS = 100;
  localparam int AUTO_CYCLES = AUTO_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // ****************************************
  // Widths
  // ****************************************
  localparam int HO_W = 20;
  localparam int CNT_W = 24;
  localparam int LVL_W = 16;
  localparam int DLY_W = 32;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEVEL = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam logic [7:0] REG_HOLDOFF = 8'h0C;
  localparam logic [7:0] REG_HO_STEP = 8'h10;
  localparam logic [7:0] REG_DELAY = 8'h14;
  localparam logic [7:0] REG_SKEW_INT = 8'h18;
  localparam logic [7:0] REG_SKEW_EXT = 8'h1C;
  localparam logic [7:0] REG_SKEW_SLV = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_EFF_LEVEL = 8'h28;
  localparam logic [7:0] REG_LEVEL_MAX = 8'h2C;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_NEG_BIT = 0;
  localparam int CTRL_GAP_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_AUTO_BIT = 4;
  localparam int STEP_UP_BIT = 0;
  localparam int STEP_DN_BIT = 1;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam logic signed [LVL_W-1:0] LEVEL_MAX = 16'sh07D0;
  localparam logic signed [LVL_W-1:0] LEVEL_RST = 16'sh0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SRC_OWN_RF = 2'h0,
    SRC_EXT = 2'h1,
    SRC_CROSS = 2'h2
  } trig_src_t;

  typedef struct packed {
    logic auto_en;
    trig_src_t source;
    logic gap_mode;
    logic neg_slope;
  } trig_ctrl_t;

  localparam trig_ctrl_t CTRL_RST = '{1'b0, SRC_OWN_RF, 1'b0, 1'b0};

endpackage

/* design/qual_timer.sv */
/*
  Loadable down counter used for holdoff and auto-trigger timing.
  Assumes one clock, asynchronous active-low reset, clock enable.
*/
`timescale 1ns/1ps
module qual_timer #(
  parameter int W = 24
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_value_i,
  output logic busy_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // ****************************************
  // Count down to zero, reload on request
  // ****************************************
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = load_value_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (enable_i) begin
      count <= next_count;
    end
  end

  assign busy_o = (count != '0);

endmodule // qual_timer

/* sim/trigger_holdoff_qualifier_assertions.sv */
/*
  Port checker for the trigger qualifier, with a shadow of its settings.
  Assumes settings are not rewritten while a trigger edge is pending.
*/
`timescale 1ns/1ps
module thq_checker #(
  parameter int AUTO_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clock_en_i,
  input wire logic signed [15:0] rf_level_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic trigger_o,
  input wire logic sweep_start_o,
  input wire logic [31:0] acq_delay_o
);
  // ****************
  // Shadow settings
  // ****************
  logic [31:0] sh [0:8];
  logic signed [15:0] rf_q;
  logic [23:0] since;
  logic signed [16:0] eff;
  logic [15:0] sk;
  logic [20:0] hc;
  logic own, rise, fall, rd_eff, auto_on;
  logic [31:0] idle_run;
  assign eff = 17'(signed'(sh[1][15:0])) + 17'(signed'(sh[2][15:0]));
  assign sk = sh[0][3:2] == 2'h1 ? sh[7][15:0] :
    sh[0][3:2] == 2'h2 ? sh[8][15:0] : sh[6][15:0];
  assign hc = (21'(sh[3][19:0]) + 21'h9) / 21'hA;
  assign own = sh[0][3:2] == 2'h0 || sh[0][3:2] == 2'h3;
  assign rise = clock_en_i && rf_q < eff && rf_level_i >= eff;
  assign fall = clock_en_i && rf_q >= eff && rf_level_i < eff;
  assign rd_eff = rd_i && clock_en_i && addr_i == 8'h28;
  assign auto_on = sh[0][4];
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh <= '{default: '0};
      rf_q <= '0;
      since <= '1;
    end else if (clock_en_i) begin
      rf_q <= rf_level_i;
      if (trigger_o) begin
        since <= 24'h000001;
      end else if (since != '1) begin
        since <= since + 24'h000001;
      end
      if (wr_i && addr_i == trig_qual_pkg::REG_LEVEL) begin
        sh[1] <= $signed(wr_data_i[15:0]) > trig_qual_pkg::LEVEL_MAX ?
          32'h7D0 : wr_data_i;
      end else if (wr_i && addr_i == trig_qual_pkg::REG_HO_STEP) begin
        if (wr_data_i[0]) begin
          sh[3] <= sh[3] + 32'h64;
        end else if (wr_data_i[1]) begin
          sh[3] <= sh[3] < 32'h64 ? 32'h0 : sh[3] - 32'h64;
        end
      end else if (wr_i && addr_i[1:0] == 2'h0 && addr_i[7:2] < 6'h9) begin
        sh[addr_i[7:2]] <= wr_data_i;
      end
    end
  end
  // Cycles since the last own-source edge or sweep while auto is on
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_run <= '0;
    end else if (clock_en_i) begin
      if (!auto_on || !own || sweep_start_o || (sh[0][0] ? fall : rise)) begin
        idle_run <= '0;
      end else if (idle_run != '1) begin
        idle_run <= idle_run + 32'h00000001;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_eff;
    $past(rd_eff) |-> rd_data_o == 32'($past(eff));
  endproperty
  a_eff: assert property (p_eff)
    else $error("offset level read wrong");
  property p_rise;
    own && !sh[0][0] && hc == 0 && rise |=> trigger_o;
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising crossing not taken");
  property p_fall;
    own && sh[0][0] && hc == 0 && fall |=> trigger_o;
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling crossing not taken");
  property p_cause;
    trigger_o && own && !sh[0][0] |-> $past(rise);
  endproperty
  a_cause: assert property (p_cause)
    else $error("trigger without rising crossing");
  property p_pulse;
    trigger_o |=> !trigger_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("trigger longer than one cycle");
  property p_sweep;
    trigger_o |-> sweep_start_o;
  endproperty
  a_sweep: assert property (p_sweep)
    else $error("trigger without sweep");
  property p_auto;
    !auto_on && !$past(auto_on) |-> sweep_start_o == trigger_o;
  endproperty
  a_auto: assert property (p_auto)
    else $error("sweep without trigger in normal mode");
  property p_delay;
    sweep_start_o |-> acq_delay_o == sh[5] + 32'(signed'(sk));
  endproperty
  a_delay: assert property (p_delay)
    else $error("acquisition delay wrong");
  property p_dead;
    trigger_o && !sh[0][1] && hc != 0 |-> since >= 24'(hc);
  endproperty
  a_dead: assert property (p_dead)
    else $error("trigger inside holdoff");
  property p_auto_gap;
    auto_on && own |-> idle_run <= 32'(AUTO_CYCLES) + 32'h00000001;
  endproperty
  a_auto_gap: assert property (p_auto_gap)
    else $error("auto sweep overdue");
  c_gap: cover property (trigger_o && sh[0][1] && hc != 0);
  c_auto: cover property (sweep_start_o && !trigger_o);
  c_neg: cover property (trigger_o && sh[0][0]);
endmodule // thq_checker
bind trigger_holdoff_qualifier thq_checker #(
  .AUTO_CYCLES(AUTO_CYCLES)
) u_chk (.clock_i, .reset_n_i, .clock_en_i, .rf_level_i, .addr_i,
  .wr_data_i, .wr_i, .rd_i, .rd_data_o, .trigger_o, .sweep_start_o,
  .acq_delay_o);

/* sim/trig_src_model.sv */
/*
  Far-side source: RF envelope and the two trigger pins.
  Assumes one pulse request at a time, driven by the bench.
*/
`timescale 1ns/1ps
module trig_src_model #(
  parameter logic signed [15:0] HIGH = 16'sh0DAC,
  parameter logic signed [15:0] LOW = -16'sh01F4
) (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [1:0] which_i,
  input wire logic [7:0] width_i,
  output logic signed [15:0] rf_level_o,
  output logic ext_o,
  output logic cross_o
);
  logic [7:0] left = 8'h00;
  logic [1:0] sel = 2'h0;
  logic tog = 1'b0;
  always_ff @(posedge clock_i) begin
    tog <= !tog;
    if (go_i) begin
      left <= width_i;
      sel <= which_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Idle envelope wanders by one step, well below the threshold
  assign rf_level_o = (left != 8'h00 && sel == 2'h0) ? HIGH :
    LOW - 16'(tog);
  assign ext_o = left != 8'h00 && sel == 2'h1;
  assign cross_o = left != 8'h00 && sel == 2'h2;
endmodule // trig_src_model

/* sim/test_trigger_holdoff_qualifier.sv */
/*
  Self-checking bench for the trigger qualifier.
  Assumes the source model on the far side and a 10 MHz clock.
*/
`timescale 1ns/1ps
module test_trigger_holdoff_qualifier;
  typedef struct {
    string name;
    logic [31:0] val;
    logic [31:0] mask;
  } note_t;
  note_t notes[$];
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clock_en_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic go = 1'b0;
  logic [1:0] which = 2'h0;
  logic rd_seen = 1'b0;
  logic signed [15:0] rf_level_i;
  logic ext, cross_pin, trigger_o, sweep_start_o, armed_o;
  logic [31:0] rd_data_o, acq_delay_o, dly;
  logic [15:0] sk [0:2];
  int fails = 0, total_checks = 0, trigs = 0, sweeps = 0, exp_trigs = 0;
  int gaps [4] = '{5, 5, 40, 5};
  initial forever #50 clock_i = !clock_i;
  trig_src_model src (.clock_i, .go_i(go), .which_i(which),
    .width_i(8'h03), .rf_level_o(rf_level_i), .ext_o(ext),
    .cross_o(cross_pin));
  trigger_holdoff_qualifier #(.AUTO_CYCLES(20)) dut (.clock_i, .reset_n_i,
    .clock_en_i, .rf_level_i, .multi_io_input_i(ext), .cross_trig_i(cross_pin),
    .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .trigger_o,
    .sweep_start_o, .armed_o, .acq_delay_o);
  // ****************
  // Tasks
  // ****************
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    @(posedge clock_i);
    notes.push_back('{$sformatf("reg %h", a), e, m});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  task automatic pulse(logic [1:0] w, int gap, int hit);
    @(posedge clock_i);
    go <= 1'b1;
    which <= w;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (gap + 3) @(posedge clock_i);
    exp_trigs += hit;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************
  // Output watcher
  // ****************
  always @(posedge clock_i) begin
    if (trigger_o === 1'b1) trigs++;
    if (sweep_start_o === 1'b1) sweeps++;
    if (rd_seen && notes.size() > 0) begin
      check(notes[0].name, notes[0].val & notes[0].mask,
        rd_data_o & notes[0].mask);
      notes.delete(0);
    end
    rd_seen = rd_i && clock_en_i;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    print_verdict();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    int k;
    dly = $urandom(32'hA3D83E28);
    foreach (sk[i]) sk[i] = 16'($urandom);
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h2C, 32'h7D0);
    wr(8'h04, 32'hBB8);
    rd(8'h04, 32'h7D0);
    wr(8'h04, 32'h3E8);
    wr(8'h08, 32'h7D0);
    wr(8'h28, 32'h0);
    rd(8'h28, 32'hBB8);
    rd(8'h2C, 32'hFA0);
    rd(8'h30, 32'h0);
    clock_en_i <= 1'b0;
    wr(8'h04, 32'h0);
    clock_en_i <= 1'b1;
    rd(8'h04, 32'h3E8);
    wr(8'h14, dly);
    for (int i = 0; i < 3; i++) wr(8'h18 + 8'(i * 4), {16'h0, sk[i]});
    for (int s = 0; s < 4; s++) begin
      k = s == 3 ? 0 : s;
      wr(8'h00, 32'(s << 2));
      for (int w = 0; w < 3; w++) begin
        pulse(2'(w), 5, int'(w == k));
        check("trigger count", exp_trigs, trigs);
        if (w == k) check("acq delay", dly + 32'(signed'(sk[k])),
          acq_delay_o);
      end
    end
    wr(8'h00, 32'h1);
    pulse(2'h0, 5, 1);
    check("neg slope count", exp_trigs, trigs);
    wr(8'h00, 32'h2);
    repeat (3) pulse(2'h0, 5, 1);
    check("zero gap count", exp_trigs, trigs);
    wr(8'h10, 32'h1);
    rd(8'h0C, 32'h64);
    wr(8'h10, 32'h2);
    wr(8'h10, 32'h2);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h0C, 32'hF5);
    repeat (40) @(posedge clock_i);
    foreach (gaps[i]) pulse(2'h0, gaps[i], int'(i == 0 || gaps[i - 1] == 40));
    check("gap count", exp_trigs, trigs);
    wr(8'h00, 32'h0);
    repeat (40) @(posedge clock_i);
    for (int i = 0; i < 5; i++) begin
      pulse(2'h0, 5, int'(i % 3 == 0));
      if (i == 0) check("armed busy", 32'h0, 32'(armed_o));
    end
    check("dead count", exp_trigs, trigs);
    repeat (40) @(posedge clock_i);
    check("armed idle", 32'h1, 32'(armed_o));
    rd(8'h24, 32'(exp_trigs) << 16, 32'hFFFF0000);
    wr(8'h00, 32'h10);
    k = sweeps;
    repeat (70) @(posedge clock_i);
    check("auto sweeps", 32'h1, 32'(sweeps - k >= 2));
    check("auto trig", exp_trigs, trigs);
    pulse(2'h0, 5, 1);
    check("auto resync", exp_trigs, trigs);
    print_verdict();
  end
endmodule // test_trigger_holdoff_qualifier
